// ### verilog/bcc_cfg.svh
`ifndef BCC_CFG_SVH
`define BCC_CFG_SVH
// link widths and address map sizes
`define BCC_ADDR_W 21
`define BCC_LOG_W 20
`define BCC_WCNT_W 8
`define BCC_IDX_W 10
`define BCC_OFF_W 10
`define BCC_MAP_DEPTH 1024
`define BCC_PAGE_W 11
// transfer mode codes, {map_table_load_flag, direction_inbound}
`define BCC_MODE_OUT 2'h0
`define BCC_MODE_IN 2'h1
`define BCC_MODE_LOAD 2'h3
`define BCC_MODE_BAD 2'h2
// link clock half period in clk_sys cycles, and the least that the synchronisers allow
`define BCC_SYNC_HALF 6
`define BCC_SYNC_MIN_HALF 6
`endif

// ### verilog/bcc_pkg.sv
`default_nettype none
`include "bcc_cfg.svh"
package bcc_pkg;
   typedef enum logic [1:0] {
      BCC_OUT = `BCC_MODE_OUT,
      BCC_IN = `BCC_MODE_IN,
      BCC_BAD = `BCC_MODE_BAD,
      BCC_LOAD = `BCC_MODE_LOAD
   } bcc_mode_t;
   typedef enum logic [1:0] {
      BCC_D_IDLE = 2'h0,
      BCC_D_ERR = 2'h1,
      BCC_D_BURST = 2'h2,
      BCC_D_FIN = 2'h3
   } bcc_dev_state_t;
   typedef enum logic [1:0] {
      BCC_R_IDLE = 2'h0,
      BCC_R_DRIVE = 2'h1,
      BCC_R_BURST = 2'h2
   } bcc_req_state_t;
   // parity bit that makes address plus parity carry an odd number of ones
   function automatic logic bcc_odd_par(input logic [`BCC_ADDR_W-1:0] a);
      return ~^a;
   endfunction
endpackage
`default_nettype wire

// ### verilog/bcc_link_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "bcc_cfg.svh"
interface bcc_link_if;
   logic sync_clk;
   logic ready;
   logic addr_error;
   logic burst_end;
   logic selected;
   logic addr_oe;
   logic [`BCC_ADDR_W-1:0] burst_start_address;
   logic start_address_parity;
   logic parity_check_enable;
   logic map_translate_enable;
   logic direction_inbound;
   logic map_table_load_flag;
   logic [`BCC_WCNT_W-1:0] burst_length_minus_one;
   modport dev (
      output sync_clk, ready, addr_error, burst_end,
      input selected, addr_oe, burst_start_address, start_address_parity, parity_check_enable,
      input map_translate_enable, direction_inbound, map_table_load_flag, burst_length_minus_one
   );
   modport req (
      input sync_clk, ready, addr_error, burst_end,
      output selected, addr_oe, burst_start_address, start_address_parity, parity_check_enable,
      output map_translate_enable, direction_inbound, map_table_load_flag, burst_length_minus_one
   );
endinterface
`default_nettype wire

// ### verilog/bcc_requester.sv
`timescale 1ns/10ps
`default_nettype none
`include "bcc_cfg.svh"
module bcc_requester
   import bcc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   bcc_link_if.req lnk,
   input wire logic start,
   input wire logic [`BCC_ADDR_W-1:0] start_addr,
   input wire logic par_en,
   input wire logic map_en,
   input wire logic dir_in,
   input wire logic map_load,
   input wire logic [`BCC_WCNT_W-1:0] len_m1,
   input wire logic blank_word,
   output logic busy,
   output logic done,
   output logic addr_err_seen
);
   bcc_req_state_t state_r;
   logic pend_r;
   logic [`BCC_ADDR_W-1:0] a_r;
   logic pe_r, me_r, di_r, ml_r, blank_r;
   logic [`BCC_WCNT_W-1:0] len_r;
   logic [3:0] s1_r, s2_r;
   logic clk_d_r;
   logic rise;
   logic ready_s, err_s, end_s;

   // link inputs come from another domain: two flops before use
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s1_r <= 4'h0;
         s2_r <= 4'h0;
         clk_d_r <= 1'b0;
      end else begin
         s1_r <= {lnk.sync_clk, lnk.ready, lnk.addr_error, lnk.burst_end};
         s2_r <= s1_r;
         clk_d_r <= s2_r[3];
      end
   end
   assign rise = s2_r[3] & ~clk_d_r;
   assign ready_s = s2_r[2];
   assign err_s = s2_r[1];
   assign end_s = s2_r[0];

   // a start while busy is ignored
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pend_r <= 1'b0;
         a_r <= '0;
         pe_r <= 1'b0;
         me_r <= 1'b0;
         di_r <= 1'b0;
         ml_r <= 1'b0;
         len_r <= '0;
         blank_r <= 1'b0;
      end else if (start && !pend_r && state_r == BCC_R_IDLE) begin
         pend_r <= 1'b1;
         a_r <= start_addr;
         pe_r <= par_en;
         me_r <= map_en;
         di_r <= dir_in | map_load;
         ml_r <= map_load;
         len_r <= len_m1;
         blank_r <= blank_word;
      end else if (rise && state_r == BCC_R_IDLE && ready_s) begin
         pend_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_r <= BCC_R_IDLE;
         lnk.selected <= 1'b0;
         lnk.addr_oe <= 1'b0;
         lnk.burst_start_address <= '0;
         lnk.start_address_parity <= 1'b0;
         lnk.parity_check_enable <= 1'b0;
         lnk.map_translate_enable <= 1'b0;
         lnk.direction_inbound <= 1'b0;
         lnk.map_table_load_flag <= 1'b0;
         lnk.burst_length_minus_one <= '0;
         done <= 1'b0;
         addr_err_seen <= 1'b0;
      end else begin
         done <= 1'b0;
         addr_err_seen <= 1'b0;
         if (rise) begin
            case (state_r)
               BCC_R_IDLE: begin
                  if (pend_r && ready_s) begin
                     state_r <= BCC_R_DRIVE;
                     lnk.selected <= 1'b1;
                     lnk.addr_oe <= ~blank_r;
                     lnk.burst_start_address <= blank_r ? '0 : a_r;
                     lnk.start_address_parity <= blank_r ? 1'b0 : bcc_odd_par(a_r);
                     lnk.parity_check_enable <= pe_r;
                     lnk.map_translate_enable <= me_r;
                     lnk.direction_inbound <= di_r;
                     lnk.map_table_load_flag <= ml_r;
                     lnk.burst_length_minus_one <= len_r;
                  end
               end
               BCC_R_DRIVE: begin
                  lnk.addr_oe <= 1'b0;
                  lnk.burst_start_address <= '0;
                  lnk.start_address_parity <= 1'b0;
                  if (err_s) begin
                     state_r <= BCC_R_IDLE;
                     lnk.selected <= 1'b0;
                     addr_err_seen <= 1'b1;
                  end else begin
                     state_r <= BCC_R_BURST;
                  end
               end
               BCC_R_BURST: begin
                  if (end_s) begin
                     state_r <= BCC_R_IDLE;
                     lnk.selected <= 1'b0;
                     done <= 1'b1;
                  end
               end
               default: begin
                  state_r <= BCC_R_IDLE;
                  lnk.selected <= 1'b0;
               end
            endcase
         end
      end
   end
   assign busy = pend_r | (state_r != BCC_R_IDLE);
endmodule // bcc_requester
`default_nettype wire

// ### verilog/bcc_device.sv
// Function
// - requester presents word on edge after ready
// - requester drives address, parity, all control lines
// - unmapped start address is 21-bit physical
// - logical address is 20 bits, top line ignored
// - requester sets odd parity over all lines; here the parity bit covers the address lines only
// - map enable marks address logical, translate
// - parity enable checks address and data words
// - mode from load flag and direction
// - word count field is words minus one
// - requesters should keep bursts short
// - parity error logged, error line next cycle
// - parity error cancels the whole transaction
// - undriven address lines give parity error
// - ready returns after address parity error
// - unmapped burst increments physical address per word
// - mapped burst increments logical, translates each
// - page index selects slot, joined with offset
// - offset carry moves to next map slot
// - every mapped access checks translation validity; here a map load burst is neither translated nor checked
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "bcc_cfg.svh"
module bcc_device
   import bcc_pkg::*;
#(
   parameter int HALF = `BCC_SYNC_HALF,
   parameter int PAGE_W = `BCC_PAGE_W
)
(
   input wire logic clk_sys,
   input wire logic reset,
   bcc_link_if.dev lnk,
   input wire logic word_step,
   input wire logic [PAGE_W:0] map_wdata,
   input wire logic chdef_clear,
   output logic chdef_addr_perr,
   output logic [`BCC_ADDR_W-1:0] mem_addr,
   output logic mem_valid,
   output logic prot_err,
   output bcc_mode_t mode,
   output logic data_par_check,
   output logic [`BCC_WCNT_W-1:0] words_left,
   output logic busy
);
   localparam int SYNC_W = 7 + `BCC_ADDR_W + `BCC_WCNT_W;

   // the requester acts three cycles after a rise and its lines need two more to cross in,
   // so a shorter half period would miss the control word at the fall
   if (HALF < `BCC_SYNC_MIN_HALF || HALF > 255) begin : g_half_chk
      $error("bcc_device: HALF out of range");
   end
   if (PAGE_W < 1 || PAGE_W + `BCC_OFF_W > `BCC_ADDR_W) begin : g_page_chk
      $error("bcc_device: PAGE_W out of range");
   end

   bcc_dev_state_t state_r;
   logic [7:0] div_r;
   logic fall_en;
   logic [SYNC_W-1:0] s1_r, s2_r;
   logic sel_s, oe_s, apar_s, pe_s, me_s, di_s, ml_s;
   logic [`BCC_ADDR_W-1:0] addr_s;
   logic [`BCC_WCNT_W-1:0] wc_s;
   logic perr;
   logic [`BCC_ADDR_W-1:0] addr_r;
   logic map_on_r;
   logic [PAGE_W:0] map_mem [0:`BCC_MAP_DEPTH-1];
   logic [PAGE_W:0] slot;
   logic last_step;

   // the link clock is made here; the bus cycle boundary the requester acts on is the rise,
   // so this end samples and changes its lines at the fall, half a cycle away from it
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         div_r <= 8'h00;
         lnk.sync_clk <= 1'b0;
      end else if (div_r == 8'(HALF - 1)) begin
         div_r <= 8'h00;
         lnk.sync_clk <= ~lnk.sync_clk;
      end else begin
         div_r <= div_r + 8'h01;
      end
   end
   assign fall_en = (div_r == 8'(HALF - 1)) & lnk.sync_clk;

   // requester lines cross in from its own logic: two flops before use
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= {lnk.selected, lnk.addr_oe, lnk.start_address_parity, lnk.parity_check_enable,
                  lnk.map_translate_enable, lnk.direction_inbound, lnk.map_table_load_flag,
                  lnk.burst_start_address, lnk.burst_length_minus_one};
         s2_r <= s1_r;
      end
   end
   assign {sel_s, oe_s, apar_s, pe_s, me_s, di_s, ml_s, addr_s, wc_s} = s2_r;

   // floating lines read as all zero, which is even parity, and addr_oe reads low, so a
   // requester that drives nothing always lands in the error path, parity check or not
   assign perr = ~oe_s | (pe_s & ~(^{addr_s, apar_s}));

   assign last_step = word_step && mem_valid && words_left == '0;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_r <= BCC_D_IDLE;
         lnk.ready <= 1'b1;
         lnk.addr_error <= 1'b0;
         lnk.burst_end <= 1'b0;
      end else begin
         case (state_r)
            BCC_D_IDLE: begin
               if (fall_en) begin
                  lnk.burst_end <= 1'b0;
                  if (sel_s && lnk.ready) begin
                     lnk.ready <= 1'b0;
                     if (perr) begin
                        state_r <= BCC_D_ERR;
                        lnk.addr_error <= 1'b1;
                     end else begin
                        state_r <= BCC_D_BURST;
                     end
                  end
               end
            end
            BCC_D_ERR: begin
               if (fall_en) begin
                  state_r <= BCC_D_IDLE;
                  lnk.addr_error <= 1'b0;
                  lnk.ready <= 1'b1;
               end
            end
            BCC_D_BURST: begin
               if (last_step) begin
                  state_r <= BCC_D_FIN;
               end
            end
            BCC_D_FIN: begin
               if (fall_en) begin
                  state_r <= BCC_D_IDLE;
                  lnk.burst_end <= 1'b1;
                  lnk.ready <= 1'b1;
               end
            end
            default: begin
               state_r <= BCC_D_IDLE;
               lnk.ready <= 1'b1;
               lnk.addr_error <= 1'b0;
               lnk.burst_end <= 1'b0;
            end
         endcase
      end
   end

   // channel definition error bit: a new error wins over a clear in the same cycle
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         chdef_addr_perr <= 1'b0;
      end else if (state_r == BCC_D_IDLE && fall_en && sel_s && lnk.ready && perr) begin
         chdef_addr_perr <= 1'b1;
      end else if (chdef_clear) begin
         chdef_addr_perr <= 1'b0;
      end
   end

   // control word capture and per-word address advance
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         addr_r <= '0;
         map_on_r <= 1'b0;
         mode <= BCC_OUT;
         data_par_check <= 1'b0;
         words_left <= '0;
      end else if (state_r == BCC_D_IDLE && fall_en && sel_s && lnk.ready && !perr) begin
         map_on_r <= me_s;
         // the top line carries no address bit in a logical address
         addr_r <= me_s ? {1'b0, addr_s[`BCC_LOG_W-1:0]} : addr_s;
         mode <= bcc_mode_t'({ml_s, di_s});
         data_par_check <= pe_s;
         words_left <= wc_s;
      end else if (state_r == BCC_D_BURST && word_step && mem_valid) begin
         if (map_on_r) begin
            // carry out of the offset walks into the next slot
            addr_r <= {1'b0, addr_r[`BCC_LOG_W-1:0] + `BCC_LOG_W'(1)};
         end else begin
            addr_r <= addr_r + `BCC_ADDR_W'(1);
         end
         words_left <= words_left - `BCC_WCNT_W'(1);
      end
   end

   // map slots: bit PAGE_W marks a valid translation; a load burst writes one slot per word,
   // indexed by the low bits of the running address
   always_ff @(posedge clk_sys) begin
      if (state_r == BCC_D_BURST && word_step && mem_valid && mode == BCC_LOAD) begin
         map_mem[addr_r[`BCC_IDX_W-1:0]] <= map_wdata;
      end
   end

   assign slot = map_mem[addr_r[`BCC_LOG_W-1:`BCC_OFF_W]];

   // address is recomputed from the running address every cycle, so each word is translated
   // afresh; mem_valid drops for one cycle after a step while the new address settles
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         mem_addr <= '0;
         mem_valid <= 1'b0;
         prot_err <= 1'b0;
      end else begin
         if (map_on_r && mode != BCC_LOAD) begin
            mem_addr <= `BCC_ADDR_W'({slot[PAGE_W-1:0], addr_r[`BCC_OFF_W-1:0]});
            prot_err <= (state_r == BCC_D_BURST) & ~slot[PAGE_W];
         end else begin
            mem_addr <= addr_r;
            prot_err <= 1'b0;
         end
         mem_valid <= (state_r == BCC_D_BURST) & ~word_step;
      end
   end

   assign busy = state_r != BCC_D_IDLE;
endmodule // bcc_device
`default_nettype wire

// ### dv/bcc_link_asserts.sv
`timescale 1ns/10ps
`default_nettype none
`include "bcc_cfg.svh"
module bcc_link_asserts (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic sync_clk,
   input wire logic ready,
   input wire logic addr_error,
   input wire logic burst_end,
   input wire logic selected,
   input wire logic addr_oe,
   input wire logic [`BCC_ADDR_W-1:0] burst_start_address,
   input wire logic start_address_parity,
   input wire logic parity_check_enable,
   input wire logic map_translate_enable,
   input wire logic direction_inbound,
   input wire logic map_table_load_flag,
   input wire logic [`BCC_WCNT_W-1:0] burst_length_minus_one
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic odd;
   logic [33:0] word;
   assign odd = ^{burst_start_address, start_address_parity};
   assign word = {burst_start_address, start_address_parity, parity_check_enable, map_translate_enable,
                  direction_inbound, map_table_load_flag, burst_length_minus_one};
   property p_oe_ready; $rose(addr_oe) |-> ready && selected; endproperty
   a_oe_ready: assert property (p_oe_ready) else $error("word driven without ready");
   property p_take_sel; $fell(ready) |-> selected; endproperty
   a_take_sel: assert property (p_take_sel) else $error("ready dropped with nobody selected");
   property p_word_hold;
      $rose(addr_oe) |=> (addr_oe && $stable(word))[*8] ##1 (addr_oe && $stable(word))[*3] ##1 !addr_oe;
   endproperty
   a_word_hold: assert property (p_word_hold) else $error("control word not held one bus cycle");
   property p_par_odd; addr_oe && parity_check_enable |-> odd; endproperty
   a_par_odd: assert property (p_par_odd) else $error("address parity not odd");
   property p_err_cause; $rose(addr_error) |-> !addr_oe || (parity_check_enable && !odd); endproperty
   a_err_cause: assert property (p_err_cause) else $error("address error without cause");
   property p_no_err; $fell(ready) && addr_oe && (!parity_check_enable || odd) |-> !addr_error; endproperty
   a_no_err: assert property (p_no_err) else $error("good word flagged as error");
   property p_blank_err; $fell(ready) && !addr_oe |-> addr_error; endproperty
   a_blank_err: assert property (p_blank_err) else $error("undriven word not flagged");
   property p_err_len;
      $rose(addr_error) |=> addr_error[*8] ##1 addr_error[*3] ##1 (!addr_error && ready);
   endproperty
   a_err_len: assert property (p_err_len) else $error("error not one bus cycle or ready late");
   property p_cancel; $rose(addr_error) |-> (!burst_end)[*8] ##1 (!burst_end)[*4]; endproperty
   a_cancel: assert property (p_cancel) else $error("burst completed after address error");
   property p_drop_sel; $rose(addr_error) |-> ##[1:14] !selected; endproperty
   a_drop_sel: assert property (p_drop_sel) else $error("requester kept channel after error");
   property p_end_ready; $rose(burst_end) |-> ready; endproperty
   a_end_ready: assert property (p_end_ready) else $error("ready not back at burst end");
   c_err: cover property ($rose(addr_error));
   c_end: cover property ($rose(burst_end));
   c_map: cover property ($rose(addr_oe) && map_translate_enable && sync_clk);
endmodule // bcc_link_asserts
`default_nettype wire

// ### dv/tb_burst_channel_ctrl_word_and_map.sv
`timescale 1ns/10ps
`default_nettype none
`include "bcc_cfg.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %0t mismatch at line %0d", $time, `__LINE__); end end
module tb_burst_channel_ctrl_word_and_map import bcc_pkg::*;;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic start = 1'b0, par_en = 1'b0, map_en = 1'b0, dir_in = 1'b0, map_load = 1'b0;
   logic blank_word = 1'b0, word_step = 1'b0, chdef_clear = 1'b0;
   logic [20:0] start_addr = 21'h0;
   logic [7:0] len_m1 = 8'h0;
   logic [11:0] map_wdata = 12'h0;
   logic req_busy, done, addr_err_seen, chdef_addr_perr, mem_valid, prot_err, data_par_check, dev_busy;
   logic [20:0] mem_addr;
   logic [7:0] words_left;
   bcc_mode_t mode;
   int failures = 0, check_count = 0, cycles = 0;
   bcc_link_if lnk();
   bcc_device bcc_device_inst (.clk_sys(clk_sys), .reset(reset), .lnk(lnk), .word_step(word_step),
      .map_wdata(map_wdata), .chdef_clear(chdef_clear), .chdef_addr_perr(chdef_addr_perr), .mem_addr(mem_addr),
      .mem_valid(mem_valid), .prot_err(prot_err), .mode(mode), .data_par_check(data_par_check),
      .words_left(words_left), .busy(dev_busy));
   bcc_requester bcc_requester_inst (.clk_sys(clk_sys), .reset(reset), .lnk(lnk), .start(start),
      .start_addr(start_addr), .par_en(par_en), .map_en(map_en), .dir_in(dir_in), .map_load(map_load),
      .len_m1(len_m1), .blank_word(blank_word), .busy(req_busy), .done(done), .addr_err_seen(addr_err_seen));
   bcc_link_asserts bcc_link_asserts_inst (.clk_sys(clk_sys), .reset(reset), .sync_clk(lnk.sync_clk),
      .ready(lnk.ready), .addr_error(lnk.addr_error), .burst_end(lnk.burst_end), .selected(lnk.selected),
      .addr_oe(lnk.addr_oe), .burst_start_address(lnk.burst_start_address),
      .start_address_parity(lnk.start_address_parity), .parity_check_enable(lnk.parity_check_enable),
      .map_translate_enable(lnk.map_translate_enable), .direction_inbound(lnk.direction_inbound),
      .map_table_load_flag(lnk.map_table_load_flag), .burst_length_minus_one(lnk.burst_length_minus_one));
   initial forever #2.5 clk_sys = ~clk_sys;
   task print_verdict;
      if (failures == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // f packs {par_en, map_en, dir_in, map_load}
   task go(input logic [20:0] a, input logic [3:0] f, input logic [7:0] n, input logic b);
      @(posedge clk_sys);
      {par_en, map_en, dir_in, map_load} <= f;
      start_addr <= a;
      len_m1 <= n;
      blank_word <= b;
      start <= 1'b1;
      @(posedge clk_sys);
      start <= 1'b0;
   endtask
   // md is only consumed by map load bursts
   task step(input logic [20:0] ea, input logic [7:0] wl, input logic pe, input logic [11:0] md);
      int i;
      i = 0;
      do begin
         @(negedge clk_sys);
         i++;
      end while (mem_valid !== 1'b1 && i < 500);
      `CHK(mem_valid, 1'b1)
      `CHK(mem_addr, ea)
      `CHK(words_left, wl)
      `CHK(prot_err, pe)
      @(posedge clk_sys);
      word_step <= 1'b1;
      map_wdata <= md;
      @(posedge clk_sys);
      word_step <= 1'b0;
   endtask
   task fin(output logic d, output logic e);
      int i;
      d = 1'b0;
      e = 1'b0;
      for (i = 0; i < 500 && !(d || e); i++) begin
         @(negedge clk_sys);
         d = (done === 1'b1);
         e = (addr_err_seen === 1'b1);
      end
   endtask
   task t_blank;
      logic d, e;
      go(21'h00a5a5, 4'h0, 8'h03, 1'b1);
      fin(d, e);
      `CHK(e, 1'b1)
      `CHK(d, 1'b0)
      `CHK(mem_valid, 1'b0)
      `CHK(chdef_addr_perr, 1'b1)
      `CHK(dev_busy, 1'b1)
      `CHK(req_busy, 1'b0)
      @(posedge clk_sys);
      chdef_clear <= 1'b1;
      @(posedge clk_sys);
      chdef_clear <= 1'b0;
      @(negedge clk_sys);
      `CHK(chdef_addr_perr, 1'b0)
   endtask
   task t_unmapped;
      logic d, e;
      go(21'h1ffffe, 4'h8, 8'h02, 1'b0);
      step(21'h1ffffe, 8'h02, 1'b0, 12'h0);
      `CHK(mode, BCC_OUT)
      `CHK(data_par_check, 1'b1)
      step(21'h1fffff, 8'h01, 1'b0, 12'h0);
      step(21'h000000, 8'h00, 1'b0, 12'h0);
      fin(d, e);
      `CHK(d, 1'b1)
      `CHK(dev_busy, 1'b0)
      `CHK(req_busy, 1'b0)
   endtask
   task t_load;
      logic d, e;
      go(21'h0003fe, 4'h3, 8'h02, 1'b0);
      step(21'h0003fe, 8'h02, 1'b0, {1'b1, 11'h123});
      `CHK(mode, BCC_LOAD)
      step(21'h0003ff, 8'h01, 1'b0, {1'b1, 11'h7ab});
      step(21'h000400, 8'h00, 1'b0, 12'h000);
      fin(d, e);
      `CHK(d, 1'b1)
   endtask
   // top line set on purpose: a logical start must ignore it
   task t_mapped;
      logic d, e;
      go(21'h1ffbff, 4'h6, 8'h02, 1'b0);
      step({11'h123, 10'h3ff}, 8'h02, 1'b0, 12'h0);
      `CHK(mode, BCC_IN)
      `CHK(data_par_check, 1'b0)
      step({11'h7ab, 10'h000}, 8'h01, 1'b0, 12'h0);
      step({11'h7ab, 10'h001}, 8'h00, 1'b0, 12'h0);
      fin(d, e);
      `CHK(d, 1'b1)
   endtask
   task t_prot;
      logic d, e;
      go(21'h000005, 4'h4, 8'h00, 1'b0);
      step({11'h000, 10'h005}, 8'h00, 1'b1, 12'h0);
      fin(d, e);
      `CHK(d, 1'b1)
   endtask
   task t_long;
      logic d, e;
      int i;
      go(21'h000100, 4'h0, 8'hff, 1'b0);
      for (i = 0; i < 256; i++)
         step(21'h000100 + 21'(i), 8'hff - 8'(i), 1'b0, 12'h0);
      fin(d, e);
      `CHK(d, 1'b1)
   endtask
   // hang guard: the whole sequence needs well under a tenth of this
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         print_verdict();
      end
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      reset <= 1'b0;
      t_blank();
      t_unmapped();
      t_load();
      t_mapped();
      t_prot();
      t_long();
      print_verdict();
   end
endmodule // tb_burst_channel_ctrl_word_and_map
`default_nettype wire
